// [design/flos_consts.vh]
/*
 * Constants of the field and line output sequencer: register offsets,
 * field positions, reset values and sequencing counts.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
// Overview of operation
// R1 - Line strobe rising edge clocks, switches outputs
// R2 - Strobe high strong drive, low weak
// R3 - Sample field level at each strobe rise
// R4 - Fix order 4th/3rd rise after field edge
// R5 - Repeat order every 12 or 6 pulses
// R6 - Controller: field high first, low second
// R7 - Controller: some modes pulse field low per line
// R8 - Single rate: first field positive, second negative
// R9 - Single rate: two units alternate sample/output
// R10 - Double rate: two samples, output per half
// R11 - Inversion select low per field, high per line
// R12 - Shift bit one samples, zero holds
// R13 - Rate select low single, high double
// R14 - Selects are static, sampled continuously
`ifndef FLOS_CONSTS_VH
`define FLOS_CONSTS_VH

// Register byte offsets
`define FLOS_OFF_CTRL 12'h000
`define FLOS_OFF_STATUS 12'h004
`define FLOS_OFF_PHASE 12'h008
`define FLOS_OFF_LINE_LEN 12'h00C

// Control register fields
`define FLOS_CTRL_ENABLE 0
`define FLOS_CTRL_FORCE_WEAK 1
`define FLOS_CTRL_RESET_VAL 32'h0000_0001

// Status register fields
`define FLOS_ST_FIELD_FIRST 0
`define FLOS_ST_ORDER_FIXED 1
`define FLOS_ST_POL_NEG 2
`define FLOS_ST_RATE_DOUBLE 3
`define FLOS_ST_INV_LINE 4
`define FLOS_ST_SEQ_A 5
`define FLOS_ST_SEQ_B 6
`define FLOS_ST_PENDING 7

// Sequencing counts
`define FLOS_FIX_DOUBLE 4'h4
`define FLOS_FIX_SINGLE 4'h3
`define FLOS_PERIOD_DOUBLE 4'hC
`define FLOS_PERIOD_SINGLE 4'h6

// Sample and hold unit codes
`define FLOS_UNIT_A 2'h0
`define FLOS_UNIT_B 2'h1
`define FLOS_UNIT_C 2'h2
`define FLOS_UNIT_D 2'h3

`endif

// [design/flos_sequencer.v]
/*
 * Field and line output sequencer of a column driver: tracks the field,
 * fixes and repeats the output order, picks sample and hold units,
 * sets polarity and buffer drive, and runs the sampling shift register.
 * Assumes all pins synchronous to clk and an APB master for registers.
 */
`timescale 1ns/1ps
`include "flos_consts.vh"

module flos_sequencer #(
    parameter NUM_OUT = 120,
    parameter LEN_W = 16
) (
    input wire clk,
    input wire srst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Timing controller strobes and static selects
    input wire line_strobe,
    input wire field_ident,
    input wire rate_select,
    input wire inv_select,
    input wire colour_seq_select_a,
    input wire colour_seq_select_b,
    // Sampling shift register
    input wire shift_step,
    input wire shift_right,
    input wire chain_port_left_in,
    output reg chain_port_left_out,
    output reg chain_port_left_oe,
    input wire chain_port_right_in,
    output reg chain_port_right_out,
    output reg chain_port_right_oe,
    output reg [NUM_OUT-1:0] sample_state,
    // Output matrix
    output reg [1:0] out_unit,
    output reg [1:0] sample_unit,
    output reg polarity_neg,
    output reg drive_strong,
    output reg field_first,
    output reg order_fixed
);

    // Software control
    reg enable;
    reg force_weak;
    // Edge detection history
    reg line_q;
    reg field_q;
    // Static selects, sampled every cycle
    reg rate_double;
    reg inv_line;
    reg seq_a;
    reg seq_b;
    // Countdown to order fix, zero when idle
    reg [3:0] fix_count;
    // Position within repeating order
    reg [3:0] phase;
    // Line length measure for half-line split
    reg [LEN_W-1:0] len_count;
    reg [LEN_W-1:0] len_last;
    reg second_half;
    // Line parity for per-line inversion
    reg line_odd;
    // Control register reset image, read bit by bit
    localparam [31:0] CTRL_RESET = `FLOS_CTRL_RESET_VAL;

    wire line_rise;
    wire field_edge;
    wire [3:0] fix_target;
    wire [3:0] period;
    wire setup_phase;
    wire access_write;
    wire half_point; // Mid-line switch point in double rate

    assign line_rise = line_strobe & ~line_q;
    assign field_edge = field_ident ^ field_q;
    assign fix_target = rate_double ? `FLOS_FIX_DOUBLE : `FLOS_FIX_SINGLE;
    assign period = rate_double ? `FLOS_PERIOD_DOUBLE : `FLOS_PERIOD_SINGLE;
    assign setup_phase = psel & ~penable;
    assign access_write = psel & penable & pwrite;
    // Same cycle that raises second_half, so units switch with it
    assign half_point = rate_double & ~second_half & (len_count == (len_last >> 1));

    // Zero wait states; error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped(paddr);

    // Decode of the register window
    function addr_mapped;
        input [11:0] a;
        begin
            if (a == `FLOS_OFF_CTRL) begin
                addr_mapped = 1'b1;
            end else if (a == `FLOS_OFF_STATUS) begin
                addr_mapped = 1'b1;
            end else if (a == `FLOS_OFF_PHASE) begin
                addr_mapped = 1'b1;
            end else if (a == `FLOS_OFF_LINE_LEN) begin
                addr_mapped = 1'b1;
            end else begin
                addr_mapped = 1'b0;
            end
        end
    endfunction

    // Register writes take effect in the access phase
    always @(posedge clk) begin
        if (srst) begin
            enable <= CTRL_RESET[`FLOS_CTRL_ENABLE];
            force_weak <= CTRL_RESET[`FLOS_CTRL_FORCE_WEAK];
        end else if (access_write && paddr == `FLOS_OFF_CTRL) begin
            enable <= pwdata[`FLOS_CTRL_ENABLE];
            force_weak <= pwdata[`FLOS_CTRL_FORCE_WEAK];
        end
    end

    // Read data captured in the setup phase, stable through access
    always @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            if (paddr == `FLOS_OFF_CTRL) begin
                prdata <= {30'h0000_0000, force_weak, enable};
            end else if (paddr == `FLOS_OFF_STATUS) begin
                prdata <= {24'h0000_00, (fix_count != 4'h0), seq_b, seq_a, inv_line,
                           rate_double, polarity_neg, order_fixed, field_first};
            end else if (paddr == `FLOS_OFF_PHASE) begin
                prdata <= {26'h000_0000, line_odd, second_half, phase};
            end else if (paddr == `FLOS_OFF_LINE_LEN) begin
                prdata <= {{(32-LEN_W){1'b0}}, len_last};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Static selects and strobe history
    always @(posedge clk) begin
        if (srst) begin
            line_q <= 1'b0;
            // Track the pin so release brings no false field edge
            field_q <= field_ident;
            rate_double <= 1'b0;
            inv_line <= 1'b0;
            seq_a <= 1'b0;
            seq_b <= 1'b0;
        end else begin
            line_q <= line_strobe;
            field_q <= field_ident;
            rate_double <= rate_select; // R13 R14
            inv_line <= inv_select; // R14
            seq_a <= colour_seq_select_a; // R14
            seq_b <= colour_seq_select_b; // R14
        end
    end

    // Buffer drive follows the strobe level unless forced weak
    always @(posedge clk) begin
        if (srst) begin
            drive_strong <= 1'b0;
        end else begin
            drive_strong <= line_strobe & ~force_weak; // R2
        end
    end

    // Field capture, order fixing and repetition on strobe rises
    always @(posedge clk) begin
        if (srst) begin
            field_first <= 1'b0;
            fix_count <= 4'h0;
            phase <= 4'h0;
            order_fixed <= 1'b0;
            line_odd <= 1'b0;
        end else begin
            order_fixed <= 1'b0;
            if (field_edge && !line_rise) begin
                // Edge restarts the count toward the fix
                fix_count <= fix_target; // R4
            end else if (field_edge && line_rise) begin
                // Coincident rise already counts as the first
                fix_count <= fix_target - 4'h1; // R4
            end
            if (line_rise && enable) begin
                field_first <= field_ident; // R3
                line_odd <= ~line_odd;
                if (fix_count == 4'h1 && !field_edge) begin
                    // Order fixed: restart the sequence here
                    fix_count <= 4'h0;
                    phase <= 4'h0; // R4
                    order_fixed <= 1'b1;
                end else begin
                    if (fix_count != 4'h0 && !field_edge) begin
                        fix_count <= fix_count - 4'h1;
                    end
                    if (phase >= period - 4'h1) begin
                        phase <= 4'h0; // R5
                    end else begin
                        phase <= phase + 4'h1; // R5
                    end
                end
            end
        end
    end

    // Line length measure and half-line point
    always @(posedge clk) begin
        if (srst) begin
            len_count <= {LEN_W{1'b0}};
            len_last <= {LEN_W{1'b0}};
            second_half <= 1'b0;
        end else if (line_rise) begin
            len_last <= len_count;
            len_count <= {LEN_W{1'b0}};
            second_half <= 1'b0;
        end else begin
            if (len_count != {LEN_W{1'b1}}) begin
                len_count <= len_count + {{(LEN_W-1){1'b0}}, 1'b1};
            end
            if (rate_double && len_count == (len_last >> 1)) begin
                second_half <= 1'b1; // R10
            end
        end
    end

    // Unit selection and polarity, switched on the strobe rise; in double rate units also switch at mid line
    always @(posedge clk) begin
        if (srst) begin
            out_unit <= `FLOS_UNIT_A;
            sample_unit <= `FLOS_UNIT_D;
            polarity_neg <= 1'b0;
        end else if (enable) begin
            if (!rate_double) begin
                if (line_rise) begin
                    // A and D swap sampling and output each line
                    out_unit <= phase[0] ? `FLOS_UNIT_A : `FLOS_UNIT_D; // R1 R9
                    sample_unit <= phase[0] ? `FLOS_UNIT_D : `FLOS_UNIT_A; // R9
                end
            end else begin
                if (line_rise) begin
                    // Pair A,B and pair C,D swap each line; first of pair out
                    out_unit <= phase[0] ? `FLOS_UNIT_A : `FLOS_UNIT_C; // R1 R10
                    sample_unit <= phase[0] ? `FLOS_UNIT_C : `FLOS_UNIT_A; // R10
                end else if (half_point) begin
                    // Second half of line drives the other of the pair
                    out_unit <= {out_unit[1], 1'b1}; // R10
                    sample_unit <= {sample_unit[1], 1'b1};
                end
            end
            if (line_rise) begin
                // Per field: field level alone; per line: also line parity
                polarity_neg <= inv_line ? (~field_ident ^ line_odd)
                                         : ~field_ident; // R8 R11
            end
        end
    end

    // Sampling shift register, direction picks the chain input
    always @(posedge clk) begin
        if (srst) begin
            sample_state <= {NUM_OUT{1'b0}};
            chain_port_left_out <= 1'b0;
            chain_port_right_out <= 1'b0;
            chain_port_left_oe <= 1'b0;
            chain_port_right_oe <= 1'b0;
        end else begin
            chain_port_left_oe <= ~shift_right;
            chain_port_right_oe <= shift_right;
            if (shift_step) begin
                if (shift_right) begin
                    sample_state <= {sample_state[NUM_OUT-2:0], chain_port_left_in}; // R12
                    chain_port_right_out <= sample_state[NUM_OUT-1];
                end else begin
                    sample_state <= {chain_port_right_in, sample_state[NUM_OUT-1:1]}; // R12
                    chain_port_left_out <= sample_state[0];
                end
            end
        end
    end

endmodule

// [testbench/flos_assertions.sv]
/* Port checker of the sequencer: strobe, field, unit and shift timing.
   Assumes bind onto the sequencer top with a matching NUM_OUT. */
`timescale 1ns/1ps
module flos_assertions #(
    parameter NUM_OUT = 120
) (
    input wire clk,
    input wire srst,
    input wire line_strobe,
    input wire field_ident,
    input wire rate_select,
    input wire inv_select,
    input wire shift_step,
    input wire shift_right,
    input wire chain_port_left_in,
    input wire [NUM_OUT-1:0] sample_state,
    input wire [1:0] out_unit,
    input wire [1:0] sample_unit,
    input wire polarity_neg,
    input wire drive_strong,
    input wire field_first,
    input wire order_fixed
);
default clocking @(posedge clk); endclocking
default disable iff (srst);
// Strong drive only behind a high strobe
drive_follow_a: assert property (drive_strong |-> $past(line_strobe))
    else $error("strong drive without strobe");
// Field level taken at each strobe rise
field_take_a: assert property ($rose(line_strobe) |=> field_first == $past(field_ident))
    else $error("field not taken at strobe rise");
// Order fixing lands one edge after a rise
fix_on_rise_a: assert property (order_fixed |-> $past(line_strobe) && !$past(line_strobe, 2))
    else $error("order fixed away from strobe rise");
fix_pulse_a: assert property (order_fixed |=> !order_fixed)
    else $error("order fixed pulse too long");
// Per-field polarity follows the field level
pol_field_a: assert property ($rose(line_strobe) && !inv_select |=>
    polarity_neg == !$past(field_ident))
    else $error("per-field polarity wrong");
// Single rate pairs units A and D
single_units_a: assert property ($rose(line_strobe) && !rate_select |=>
    (out_unit ^ sample_unit) == 2'h3 && out_unit[0] == out_unit[1])
    else $error("single rate unit pair wrong");
// Double rate pairs A with C or B with D
double_units_a: assert property ($rose(line_strobe) && rate_select |=>
    (out_unit ^ sample_unit) == 2'h2)
    else $error("double rate unit pair wrong");
// Left chain bit enters bit zero
shift_in_a: assert property (shift_step && shift_right |=>
    sample_state[0] == $past(chain_port_left_in))
    else $error("shift input bit lost");
cover property (order_fixed && rate_select);
cover property (order_fixed && !rate_select);
cover property ($rose(line_strobe) && inv_select);
endmodule

// [testbench/flos_timing_ctrl.sv]
/* Timing controller model: line strobe and field level.
   Assumes the same clk as the sequencer. */
`timescale 1ns/1ps
module flos_timing_ctrl (
    input wire clk,
    input wire srst,
    input wire field_req,
    input wire field_dip,
    output reg line_strobe,
    output reg field_ident
);
reg [4:0] cnt; // Position in a 24 clk line
reg dip_on; // Field held low for the current line
// Strobe high two clk at line start
always @(posedge clk) begin
    if (srst) begin
        cnt <= 5'h00;
        line_strobe <= 1'b0;
        field_ident <= 1'b1;
        dip_on <= 1'b0;
    end else begin
        cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
        line_strobe <= (cnt == 5'h17) || (cnt == 5'h00);
        // Field moves mid line, clear of strobe edges
        if (cnt == 5'h0C) begin
            if (field_dip && !dip_on) begin
                // Low for one whole line, one strobe rise inside
                field_ident <= 1'b0;
                dip_on <= 1'b1;
            end else begin
                field_ident <= field_req;
                dip_on <= 1'b0;
            end
        end
    end
end
endmodule

// [testbench/flos_sequencer_test.sv]
/* Bench top of the sequencer: APB tasks, strobe and shift scenarios.
   Assumes the timing controller model and the port checker. */
`timescale 1ns/1ps
module flos_sequencer_test;
reg clk, srst, psel, penable, pwrite, field_req, shift_step, shift_right, tb_l, field_dip;
reg [11:0] paddr;
reg [31:0] pwdata, q;
reg [3:0] cfg; // Seq b, seq a, inversion, rate
wire [31:0] prdata;
wire [7:0] sample_state;
wire [1:0] out_unit, sample_unit;
wire pready, pslverr, line_strobe, field_ident, l_out, l_oe, r_out, r_oe;
wire polarity_neg, drive_strong, field_first, order_fixed;
int bad_count, check_count, cycles, n, k, p;
logic pv, u0, f;
flos_sequencer #(.NUM_OUT(8)) DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .line_strobe, .field_ident,
    .rate_select(cfg[0]), .inv_select(cfg[1]), .colour_seq_select_a(cfg[2]),
    .colour_seq_select_b(cfg[3]), .shift_step, .shift_right,
    .chain_port_left_in(l_oe ? l_out : tb_l), .chain_port_left_out(l_out),
    .chain_port_left_oe(l_oe), .chain_port_right_in(r_oe ? r_out : tb_l),
    .chain_port_right_out(r_out), .chain_port_right_oe(r_oe), .sample_state,
    .out_unit, .sample_unit, .polarity_neg, .drive_strong, .field_first, .order_fixed);
flos_timing_ctrl ctrl (.clk, .srst, .field_req, .field_dip, .line_strobe, .field_ident);
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
// Hang guard
always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
        bad_count++;
        finish_test();
    end
end
task finish_test();
    if (bad_count == 0 && check_count > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// One APB transfer; read data to q, error to f
task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    f = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
// Wait a strobe rise; keep the unit shown before it
task rise();
    @(posedge line_strobe);
    u0 = out_unit[0];
    repeat (3) @(negedge clk);
endtask
task pulse(input logic b);
    @(posedge clk);
    tb_l <= b;
    shift_step <= 1'b1;
    @(posedge clk);
    shift_step <= 1'b0;
endtask
// Count strobe rises until the order fixed pulse is seen
task count_fix();
    n = 0;
    f = 1'b0;
    while (f !== 1'b1 && n < 9) begin
        @(posedge line_strobe);
        n++;
        repeat (3) begin
            @(negedge clk);
            if (order_fixed === 1'b1) f = 1'b1;
        end
    end
endtask
initial begin
    {psel, penable, pwrite, shift_step, tb_l, field_dip} = 6'h00;
    shift_right = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cfg = 4'h0;
    field_req = 1'b1;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    apb(0, 12'h000, 0);
    chk(q, 32'h0000_0001);
    apb(0, 12'h010, 0);
    chk(q, 32'h0000_0000);
    chk(f, 1'b1);
    // Weak then normal drive
    for (k = 3; k > 0; k -= 2) begin
        apb(1, 12'h000, k);
        apb(0, 12'h000, 0);
        chk(q, k);
        rise();
        chk(drive_strong, k == 1);
    end
    // Left to right, then right to left
    for (k = 1; k >= 0; k--) begin
        @(posedge clk);
        shift_right <= k[0];
        pulse(1'b1);
        repeat (7) pulse(1'b0);
        @(negedge clk);
        chk(sample_state, k ? 8'h80 : 8'h01);
        pulse(1'b0);
        @(negedge clk);
        chk(k ? {r_oe, r_out} : {l_oe, l_out}, 2'h3);
    end
    // Each rate and inversion mode
    for (int m = 0; m < 4; m++) begin
        @(posedge clk);
        cfg <= {~m[1:0], m[1:0]};
        apb(0, 12'h004, 0);
        chk(q[6:3], cfg);
        field_req <= ~field_req;
        @(field_ident);
        count_fix();
        chk(n, cfg[0] ? 4 : 3);
        p = cfg[0] ? 12 : 6;
        pv = polarity_neg;
        for (k = 1; k <= p; k++) begin
            rise();
            if (cfg[0] && k > 1) chk(u0, 1);
            apb(0, 12'h008, 0);
            chk(q[3:0], k % p);
            chk(polarity_neg, cfg[1] ? !pv : !field_ident);
            pv = polarity_neg;
        end
    end
    // Double rate, field kept high but dipped low for one line
    field_dip <= 1'b1;
    @(negedge field_ident);
    field_dip <= 1'b0;
    @(posedge field_ident);
    count_fix();
    chk(n, 4);
    finish_test();
end
endmodule
bind flos_sequencer flos_assertions #(.NUM_OUT(NUM_OUT)) chk_i (.clk, .srst, .line_strobe,
    .field_ident, .rate_select, .inv_select, .shift_step, .shift_right, .chain_port_left_in,
    .sample_state, .out_unit, .sample_unit, .polarity_neg, .drive_strong, .field_first,
    .order_fixed);
